//--- design/module_ctrl_regs.svh
// Register offsets, field positions, reset values and timing counts of the control block
`ifndef MODULE_CTRL_REGS_SVH
`define MODULE_CTRL_REGS_SVH

// ----------------------------------------------------------------------------
// Clock and timing
// ----------------------------------------------------------------------------
`define CLK_MHZ 100
`define CLK_KHZ (`CLK_MHZ * 1000)
`define T_INIT_MS 2000
`define T_RESET_INIT_US 2
// Least restart pulse, rounded up to whole cycles
`define RESET_CYC (`T_RESET_INIT_US * `CLK_MHZ)
`define INIT_CYC (`T_INIT_MS * `CLK_KHZ)
`define INIT_CW 28
`define RST_CW 8

// ----------------------------------------------------------------------------
// Register indices (byte address is four times the index)
// ----------------------------------------------------------------------------
`define STATUS_IDX 6'h02
`define FLAGS_IDX 6'h03
`define MASK_IDX 6'h04
`define CTRL_IDX 6'h05

// ----------------------------------------------------------------------------
// Fields
// ----------------------------------------------------------------------------
`define NFLAG 9
`define LOS_LSB 0
`define FAULT_LSB 4
`define INIT_BIT 8
`define DNR_BIT 0
`define PD_BIT 0
`define MASK_RST 9'h000
`define FLAGS_RST 9'h000

`endif

//--- design/module_ctrl_pkg.sv
// Types shared by the module control block
package module_ctrl_pkg;

    // Life cycle of the module, one-hot
    typedef enum logic [2:0] {
        ST_HELD = 3'b001,
        ST_INIT = 3'b010,
        ST_RUN = 3'b100
    } state_t;

endpackage : module_ctrl_pkg

//--- design/pin_sync.sv
// Two-flop synchroniser for a group of pin inputs
`timescale 1ns/1ps
module pin_sync #(
    parameter int W = 1,
    parameter logic [W-1:0] RST_VAL = '0
) (
    // System
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clkEn,
    // Data
    input wire logic [W-1:0] d,
    output logic [W-1:0] q
);
    logic [W-1:0] meta_r;
    logic [W-1:0] q_r;

    // First stage feeds only the second stage
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            meta_r <= RST_VAL;
            q_r <= RST_VAL;
        end else if (clkEn) begin
            meta_r <= d;
            q_r <= meta_r;
        end
    end

    assign q = q_r;
endmodule : pin_sync

//--- design/module_ctrl_status_timing.sv
// Control and status logic of a pluggable module: init, flags, mask, select, low power
//
// The APB register port and the placing of the registers were chosen for this implementation.
`timescale 1ns/1ps
`include "module_ctrl_regs.svh"
module module_ctrl_status_timing #(
    parameter int NCH = 4,
    parameter int INIT_CYC = `INIT_CYC
) (
    // System
    input wire logic mclk,
    input wire logic nrst,
    input wire logic clkEn,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Module pins
    input wire logic hard_restart_n,
    input wire logic bus_select_n,
    input wire logic low_power_request,
    output logic alert_out_n,
    output logic lowPowerOut,
    // Per-channel conditions
    input wire logic [NCH-1:0] rxLos,
    input wire logic [NCH-1:0] txFault
);

    // ------------------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------------------
    localparam int SW = 2 * NCH + 3;
    logic [SW-1:0] syncQ;
    logic restartS;
    logic selNS;
    logic lpS;
    logic [NCH-1:0] losS;
    logic [NCH-1:0] faultS;

    // Restart and select idle high so reset does not look like a pulse
    pin_sync #(
        .W(SW),
        .RST_VAL({1'b1, 1'b1, 1'b0, {(2 * NCH){1'b0}}})
    ) u_sync (
        .mclk(mclk),
        .nrst(nrst),
        .clkEn(clkEn),
        .d({hard_restart_n, bus_select_n, low_power_request, txFault, rxLos}),
        .q(syncQ)
    );

    assign restartS = syncQ[SW-1];
    assign selNS = syncQ[SW-2];
    assign lpS = syncQ[SW-3];
    assign faultS = syncQ[2*NCH-1:NCH];
    assign losS = syncQ[NCH-1:0];

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    module_ctrl_pkg::state_t state_r, state_nxt;
    logic [`INIT_CW-1:0] initCnt_r, initCnt_nxt;
    logic [`RST_CW-1:0] rstCnt_r, rstCnt_nxt;
    logic [`NFLAG-1:0] flags_r, flags_nxt;
    logic [`NFLAG-1:0] mask_r, mask_nxt;
    logic [`NFLAG-1:0] newEv;
    logic pdown_r, pdown_nxt;
    logic dnr_r, dnr_nxt;
    logic [NCH-1:0] losP_r, losP_nxt;
    logic [NCH-1:0] faultP_r, faultP_nxt;
    logic alertN_r, alertN_nxt;
    logic lowPower_r, lowPower_nxt;
    logic [31:0] prdata_r, prdata_nxt;
    logic pready_r, pready_nxt;
    logic pslverr_r, pslverr_nxt;

    logic setup;
    logic access;
    logic busOk;
    logic mapped;
    logic [5:0] idx;
    logic [31:0] rdMux;

    assign setup = psel && !penable;
    assign access = psel && penable && pready_r;
    assign idx = paddr[7:2];
    // Select gating: deselected or held module refuses the bus
    assign busOk = !selNS && (state_r != module_ctrl_pkg::ST_HELD);
    // Only the low register window answers; anything else is refused
    assign mapped = (paddr[1:0] == 2'b00) && (idx >= `STATUS_IDX) && (idx <= `CTRL_IDX);

    // Rising edges of the conditions become flag events
    always_comb begin
        newEv = '0;
        newEv[`LOS_LSB +: NCH] = losS & ~losP_r;
        newEv[`FAULT_LSB +: NCH] = faultS & ~faultP_r;
    end

    // Read multiplexer
    always_comb begin
        rdMux = 32'h0000_0000;
        case (idx)
            `STATUS_IDX: rdMux = {28'h000_0000, lowPower_r, !selNS,
                state_r == module_ctrl_pkg::ST_RUN, dnr_r};
            `FLAGS_IDX: rdMux = {{(32 - `NFLAG){1'b0}}, flags_r};
            `MASK_IDX: rdMux = {{(32 - `NFLAG){1'b0}}, mask_r};
            `CTRL_IDX: rdMux = {31'h0000_0000, pdown_r};
            default: rdMux = 32'h0000_0000;
        endcase
    end

    // ------------------------------------------------------------------------
    // Next-state logic
    // ------------------------------------------------------------------------
    // Restart qualification, init sequencing, flags, mask and power-down writes
    always_comb begin
        state_nxt = state_r;
        initCnt_nxt = initCnt_r;
        rstCnt_nxt = rstCnt_r;
        flags_nxt = flags_r;
        mask_nxt = mask_r;
        pdown_nxt = pdown_r;
        dnr_nxt = dnr_r;
        losP_nxt = losS;
        faultP_nxt = faultS;

        // Count restart low time; short glitches are ignored
        if (!restartS) begin
            if (rstCnt_r != `RST_CW'(`RESET_CYC)) begin
                rstCnt_nxt = rstCnt_r + `RST_CW'(1);
            end
        end else begin
            rstCnt_nxt = '0;
        end

        case (state_r)
            module_ctrl_pkg::ST_HELD: begin
                dnr_nxt = 1'b1;
                flags_nxt = `FLAGS_RST;
                initCnt_nxt = '0;
                // Restart seen high starts the init timer
                if (restartS) begin
                    state_nxt = module_ctrl_pkg::ST_INIT;
                end
            end
            module_ctrl_pkg::ST_INIT: begin
                // Init ends after INIT_CYC cycles, right at the limit
                if (initCnt_r == `INIT_CW'(INIT_CYC - 1)) begin
                    state_nxt = module_ctrl_pkg::ST_RUN;
                    dnr_nxt = 1'b0;
                    flags_nxt[`INIT_BIT] = 1'b1;
                end else begin
                    initCnt_nxt = initCnt_r + `INIT_CW'(1);
                end
            end
            module_ctrl_pkg::ST_RUN: begin
                state_nxt = module_ctrl_pkg::ST_RUN;
            end
            default: begin
                state_nxt = module_ctrl_pkg::ST_HELD;
            end
        endcase

        // A qualified restart pulse overrides any state transition
        if (!restartS && rstCnt_r == `RST_CW'(`RESET_CYC - 1)) begin
            state_nxt = module_ctrl_pkg::ST_HELD;
        end

        // Register writes land at the access edge only
        if (access && pwrite && !pslverr_r) begin
            if (idx == `MASK_IDX) begin
                mask_nxt = pwdata[`NFLAG-1:0];
            end
            if (idx == `CTRL_IDX) begin
                pdown_nxt = pwdata[`PD_BIT];
            end
        end

        // Clear on read only the bits the host actually saw
        if (access && !pwrite && !pslverr_r && idx == `FLAGS_IDX) begin
            flags_nxt = flags_nxt & ~prdata_r[`NFLAG-1:0];
        end

        // A new event wins over a clear in the same cycle
        if (state_r == module_ctrl_pkg::ST_RUN) begin
            flags_nxt = flags_nxt | newEv;
        end
    end

    // Bus answers and pins, all registered so outputs come from flops
    always_comb begin
        // No wait state: answer built in setup, valid through access
        pready_nxt = setup;
        pslverr_nxt = setup && (!busOk || !mapped);
        prdata_nxt = (setup && busOk && mapped && !pwrite) ? rdMux : 32'h0000_0000;
        // Alert follows unmasked flags; mask takes effect next cycle
        alertN_nxt = !(|(flags_r & ~mask_r));
        // Pin or power-down bit both force low power
        lowPower_nxt = lpS || pdown_r;
    end

    // ------------------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------------------
    // Clock enable freezes every flop; the bus stalls with it
    always_ff @(posedge mclk or negedge nrst) begin
        if (!nrst) begin
            state_r <= module_ctrl_pkg::ST_INIT;
            initCnt_r <= '0;
            rstCnt_r <= '0;
            flags_r <= `FLAGS_RST;
            mask_r <= `MASK_RST;
            pdown_r <= 1'b0;
            dnr_r <= 1'b1;
            losP_r <= '0;
            faultP_r <= '0;
            alertN_r <= 1'b1;
            lowPower_r <= 1'b0;
            prdata_r <= 32'h0000_0000;
            pready_r <= 1'b0;
            pslverr_r <= 1'b0;
        end else if (clkEn) begin
            state_r <= state_nxt;
            initCnt_r <= initCnt_nxt;
            rstCnt_r <= rstCnt_nxt;
            flags_r <= flags_nxt;
            mask_r <= mask_nxt;
            pdown_r <= pdown_nxt;
            dnr_r <= dnr_nxt;
            losP_r <= losP_nxt;
            faultP_r <= faultP_nxt;
            alertN_r <= alertN_nxt;
            lowPower_r <= lowPower_nxt;
            prdata_r <= prdata_nxt;
            pready_r <= pready_nxt;
            pslverr_r <= pslverr_nxt;
        end
    end

    assign prdata = prdata_r;
    assign pready = pready_r;
    assign pslverr = pslverr_r;
    assign alert_out_n = alertN_r;
    assign lowPowerOut = lowPower_r;

    // ------------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------------
    default clocking cb @(posedge mclk);
    endclocking
    default disable iff (!nrst || !clkEn);

    sequence initEnds;
        state_r == module_ctrl_pkg::ST_INIT && initCnt_r == `INIT_CW'(INIT_CYC - 1)
            && restartS && rstCnt_r == '0;
    endsequence

    sequence readyShown;
        !dnr_r && flags_r[`INIT_BIT] ##1 (!alert_out_n || mask_r[`INIT_BIT]);
    endsequence

    a_init_ready: assert property (initEnds |=> readyShown)
        else $error("init end did not clear not-ready and raise alert");

    a_alert_on: assert property (|(flags_r & ~mask_r) |=> !alert_out_n)
        else $error("alert not asserted for unmasked flag");

    a_alert_off: assert property (!(|(flags_r & ~mask_r)) |=> alert_out_n)
        else $error("alert held with no unmasked flag");

    a_los_flag: assert property ((state_r == module_ctrl_pkg::ST_RUN && !losP_r[0]
        && losS[0] && !(rstCnt_r == `RST_CW'(`RESET_CYC - 1) && !restartS))
        |=> flags_r[`LOS_LSB])
        else $error("loss-of-signal flag not set");

    a_lp_pin: assert property ($rose(lpS) |=> lowPowerOut)
        else $error("low-power pin not obeyed");

    a_pdown_set: assert property ((access && pwrite && !pslverr_r
        && idx == `CTRL_IDX && pwdata[`PD_BIT]) |-> ##2 lowPowerOut)
        else $error("power-down bit not obeyed");

    a_restart_held: assert property ((!restartS && rstCnt_r == `RST_CW'(`RESET_CYC - 1))
        |=> state_r == module_ctrl_pkg::ST_HELD && rstCnt_r == `RST_CW'(`RESET_CYC))
        else $error("qualified restart not taken");

    a_deselect_refuse: assert property ((setup && selNS) |=> pready && pslverr
        && prdata == 32'h0000_0000)
        else $error("deselected module answered the bus");

    a_read_clear: assert property ((access && !pwrite && !pslverr_r && idx == `FLAGS_IDX
        && state_r == module_ctrl_pkg::ST_RUN && newEv == '0)
        |=> (flags_r & $past(prdata_r[`NFLAG-1:0])) == '0)
        else $error("flag not cleared by read");

endmodule : module_ctrl_status_timing

//--- tb/host_model.sv
// Host board model: APB master that reaches the module's registers
`timescale 1ns/1ps
module host_model (
    // System
    input wire logic mclk,
    // APB master side
    output logic psel,
    output logic penable,
    output logic pwrite,
    output logic [7:0] paddr,
    output logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr
);
    // Idle bus at time zero
    initial begin
        psel = 1'h0;
        penable = 1'h0;
        pwrite = 1'h0;
        paddr = 8'h00;
        pwdata = 32'h0000_0000;
    end

    // One transfer; no latency assumed, only the bench timeout ends a stall
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
        output logic [31:0] rd, output logic err);
        @(posedge mclk);
        psel <= 1'h1;
        penable <= 1'h0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge mclk);
        penable <= 1'h1;
        do @(posedge mclk); while (pready !== 1'h1);
        rd = prdata;
        err = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        // Released lines show no stale value
        paddr <= ~a;
        pwdata <= ~wd;
    endtask : xfer
endmodule : host_model

//--- tb/testbench.sv
// Self-checking bench of the module control and status block
`timescale 1ns/1ps
`include "module_ctrl_regs.svh"
module testbench;
    // ------------------------------------------------------------------
    // Signals and instances
    // ------------------------------------------------------------------
    localparam int INITN = 50;
    localparam logic [7:0] STA = 8'(4 * `STATUS_IDX);
    localparam logic [7:0] FLG = 8'(4 * `FLAGS_IDX);
    localparam logic [7:0] MSK = 8'(4 * `MASK_IDX);
    localparam logic [7:0] CTL = 8'(4 * `CTRL_IDX);
    logic mclk, nrst, clkEn, psel, penable, pwrite, pready, pslverr, err;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic hard_restart_n, bus_select_n, low_power_request, alert_out_n, lowPowerOut;
    logic [3:0] rxLos, txFault;
    int failures, checks_done, cyc, c;
    bit f;

    module_ctrl_status_timing #(.NCH(4), .INIT_CYC(INITN)) module_ctrl_status_timing_i (
        .mclk(mclk), .nrst(nrst), .clkEn(clkEn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .hard_restart_n(hard_restart_n),
        .bus_select_n(bus_select_n), .low_power_request(low_power_request),
        .alert_out_n(alert_out_n), .lowPowerOut(lowPowerOut), .rxLos(rxLos),
        .txFault(txFault));
    host_model host_model_i (.mclk(mclk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr));

    // 100 MHz clock
    initial begin
        mclk = 1'h0;
        forever #5 mclk = ~mclk;
    end

    // Hang guard; the whole run needs well under two thousand cycles
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            failures++;
            results();
        end
    end

    // ------------------------------------------------------------------
    // Tasks and expectations
    // ------------------------------------------------------------------
    task automatic results();
        if (failures == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checks_done++;
        if (g !== e) begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    task automatic rd32(input logic [7:0] a);
        host_model_i.xfer(1'h0, a, 32'h0000_0000, rd, err);
    endtask : rd32

    task automatic wr32(input logic [7:0] a, input logic [31:0] d);
        host_model_i.xfer(1'h1, a, d, rd, err);
    endtask : wr32

    // Bounded wait for the alert level, then compare
    task automatic waitAlert(input logic lvl, input int n);
        repeat (n) begin
            @(posedge mclk);
            if (alert_out_n === lvl) break;
        end
        check("alert_out_n", 32'(lvl), 32'(alert_out_n));
    endtask : waitAlert

    function automatic logic [31:0] flagBit(input bit fault, input int ch);
        return 32'h0000_0001 << (ch + (fault ? `FAULT_LSB : `LOS_LSB));
    endfunction : flagBit

    // Condition held long enough to pass the input synchronisers
    task automatic pulseCond(input bit fault, input int ch);
        if (fault) begin
            txFault[ch] <= 1'h1;
        end else begin
            rxLos[ch] <= 1'h1;
        end
        repeat (6) @(posedge mclk);
        rxLos <= 4'h0;
        txFault <= 4'h0;
    endtask : pulseCond

    // Start-up: not ready, then ready flag and alert
    // Status word: bit0 not ready, bit1 running, bit2 selected, bit3 low power
    task automatic initCheck();
        rd32(STA);
        check("status init", 32'h0000_0005, rd);
        repeat (INITN) @(posedge mclk);
        waitAlert(1'h0, 10);
        rd32(STA);
        check("status run", 32'h0000_0006, rd);
        rd32(FLG);
        check("init flag", 32'h0000_0001 << `INIT_BIT, rd);
        waitAlert(1'h1, 10);
    endtask : initCheck

    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        failures = 0;
        checks_done = 0;
        cyc = 0;
        nrst = 1'h0;
        clkEn = 1'h1;
        hard_restart_n = 1'h1;
        bus_select_n = 1'h0;
        low_power_request = 1'h0;
        rxLos = 4'h0;
        txFault = 4'h0;
        void'($urandom(32'h5221));
        repeat (3) @(posedge mclk);
        nrst <= 1'h1;
        repeat (3) @(posedge mclk);
        initCheck();
        // Random conditions, each read once to clear
        for (int i = 0; i < 8; i++) begin
            f = 1'($urandom_range(1, 0));
            c = int'($urandom_range(3, 0));
            pulseCond(f, c);
            waitAlert(1'h0, 10);
            rd32(FLG);
            check("flags", flagBit(f, c), rd);
            waitAlert(1'h1, 10);
            rd32(FLG);
            check("flags cleared", 32'h0000_0000, rd);
        end
        // Masking holds the alert back until unmasked
        c = int'($urandom_range(3, 0));
        wr32(MSK, flagBit(1'b0, c));
        rd32(MSK);
        check("mask", flagBit(1'b0, c), rd);
        pulseCond(1'b0, c);
        repeat (4) @(posedge mclk);
        check("alert masked", 32'h0000_0001, 32'(alert_out_n));
        wr32(MSK, 32'h0000_0000);
        waitAlert(1'h0, 10);
        pulseCond(1'b1, c);
        rd32(FLG);
        check("two flags", flagBit(1'b0, c) | flagBit(1'b1, c), rd);
        waitAlert(1'h1, 10);
        // Unmapped place is refused
        rd32(8'h40);
        check("unmapped err", 32'h0000_0001, 32'(err));
        check("unmapped data", 32'h0000_0000, rd);
        // Module select gates the bus
        bus_select_n <= 1'h1;
        repeat (4) @(posedge mclk);
        rd32(STA);
        check("deselected err", 32'h0000_0001, 32'(err));
        bus_select_n <= 1'h0;
        repeat (4) @(posedge mclk);
        rd32(STA);
        check("selected err", 32'h0000_0000, 32'(err));
        // Low power by pin and by power-down bit
        low_power_request <= 1'h1;
        repeat (5) @(posedge mclk);
        check("low power pin", 32'h0000_0001, 32'(lowPowerOut));
        low_power_request <= 1'h0;
        wr32(CTL, 32'h0000_0001 << `PD_BIT);
        repeat (3) @(posedge mclk);
        check("power down", 32'h0000_0001, 32'(lowPowerOut));
        wr32(CTL, 32'h0000_0000);
        repeat (3) @(posedge mclk);
        check("power up", 32'h0000_0000, 32'(lowPowerOut));
        // Frozen clock enable holds all state; the pin is seen once it runs again
        clkEn <= 1'h0;
        low_power_request <= 1'h1;
        repeat (5) @(posedge mclk);
        check("frozen", 32'h0000_0000, 32'(lowPowerOut));
        clkEn <= 1'h1;
        repeat (5) @(posedge mclk);
        check("thawed", 32'h0000_0001, 32'(lowPowerOut));
        low_power_request <= 1'h0;
        repeat (5) @(posedge mclk);
        check("pin released", 32'h0000_0000, 32'(lowPowerOut));
        // Short restart pulse is ignored, long one restarts
        hard_restart_n <= 1'h0;
        repeat (20) @(posedge mclk);
        hard_restart_n <= 1'h1;
        repeat (4) @(posedge mclk);
        rd32(STA);
        check("short restart", 32'h0000_0000, 32'(rd[`DNR_BIT]));
        hard_restart_n <= 1'h0;
        repeat (250) @(posedge mclk);
        rd32(STA);
        check("held err", 32'h0000_0001, 32'(err));
        hard_restart_n <= 1'h1;
        repeat (4) @(posedge mclk);
        initCheck();
        results();
    end
endmodule : testbench
